// [src/bss_params.svh]
// timing and field constants for the bias supply supervisor
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH
`define BSS_CLK_HZ        100000000
`define BSS_BAUD          9600
`define BSS_BIT_CYCLES    (`BSS_CLK_HZ / `BSS_BAUD)
`define BSS_BIT_CNT_W     14
`define BSS_FRAME_BITS    4'hA
`define BSS_MSG_STATUS0   8'h00
`define BSS_MSG_STATUS1   8'h01
`define BSS_MSG_SUPPLY    8'h02
`define BSS_ST0_BIOCP     0
`define BSS_ST0_BUCK_OUTPUT_LOW_WARNING    1
`define BSS_ST0_BUCK_LOCKOUT_FAULT    2
`define BSS_ST1_CFGLOST   0
`define BSS_ST1_UV        1
`define BSS_ST1_OV        2
`define BSS_MSG_FIELD_LSB 5
`define BSS_MODE_W        4
`define BSS_MODE_CE       3
`define BSS_MODE_SLEEP    2
`define BSS_MODE_XCVR     1
`define BSS_MODE_RELOAD   0
`endif

// [src/bss_pkg.sv]
// types shared by the bias supply supervisor
package bss_pkg;
  typedef struct packed {
    logic vdd_above_ovlo_stop;   // overvoltage stop threshold
    logic vdd_below_bk_stop;     // buck undervoltage stop threshold
    logic vdd_below_severe_uv;   // severe undervoltage
    logic vdd_below_uvlo;        // driver undervoltage
    logic vdd_above_drv_ovlo;    // driver overvoltage
    logic vdd_above_sys_ovlo;    // extreme overvoltage
    logic vdd_below_brownout;    // brownout
    logic vdd_below_pump_start;  // pump start threshold
    logic buck_ipeak_over;       // buck input peak current
    logic buck_out_below_90;
    logic buck_out_below_94;
    logic buck_out_below_80;
    logic fb_held_external;      // buck feedback input tied to supply
  } bss_sense_t;

  typedef struct packed {
    logic ldo5_en;
    logic ldo12_en;
    logic buck_en;
    logic pump_en;
    logic drivers_en;
  } bss_enables_t;

  typedef struct packed {
    logic [2:0] first_status_register;
    logic [2:0] second_status_register;
  } bss_status_t;

  typedef enum logic [1:0] {BSS_MSG_ST0, BSS_MSG_ST1} bss_msg_sel_t;
endpackage : bss_pkg

// [src/bss_sync.sv]
// two-flop synchroniser for a vector of comparator levels
`timescale 1ns/10ps
module bss_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bss_sync

// [src/bss_uart_tx.sv]
// open-drain 8N1 transmitter for the host status link
`timescale 1ns/10ps
`include "bss_params.svh"
module bss_uart_tx (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // byte request
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // line: pull low when link_oe_n is low
  output logic            link_o,
  output logic            link_oe_n
);
  localparam logic [`BSS_BIT_CNT_W-1:0] BIT_LAST =
    `BSS_BIT_CNT_W'(`BSS_BIT_CYCLES - 1);

  logic [9:0]                frame_q;
  logic [3:0]                bits_q;
  logic [`BSS_BIT_CNT_W-1:0] cnt_q;
  logic                      busy_q;
  logic                      bit_end;

  assign bit_end  = (cnt_q == BIT_LAST);
  assign tx_ready = !busy_q;
  assign link_o   = 1'b0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_q   <= '1;
      bits_q    <= '0;
      cnt_q     <= '0;
      busy_q    <= 1'b0;
      link_oe_n <= 1'b1;
    end else if (!busy_q) begin
      cnt_q <= '0;
      if (tx_valid) begin
        frame_q   <= {1'b1, tx_data, 1'b0};
        bits_q    <= `BSS_FRAME_BITS;
        busy_q    <= 1'b1;
        link_oe_n <= 1'b0;
      end
    end else if (bit_end) begin
      cnt_q     <= '0;
      frame_q   <= {1'b1, frame_q[9:1]};
      link_oe_n <= frame_q[1];
      bits_q    <= bits_q - 4'h1;
      if (bits_q == 4'h1) begin
        busy_q    <= 1'b0;
        link_oe_n <= 1'b1;
      end
    end else begin
      cnt_q <= cnt_q + `BSS_BIT_CNT_W'(1);
    end
  end

  bit_time_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    busy_q && bit_end && bits_q > 4'h1 |=> (cnt_q == '0))
    else $error("bit timer did not restart");
  idle_release_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !busy_q |-> link_oe_n)
    else $error("line pulled while idle");
endmodule : bss_uart_tx

// [src/bss_supervisor.sv]
// bias supply supervisor: rail enables, status bits and status messages
`timescale 1ns/10ps
`include "bss_params.svh"
module bss_supervisor
  import bss_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // mode and variant
  input  wire logic   chip_enable,
  input  wire logic   sleep_req,
  input  wire logic   transceiver_variant,
  input  wire logic   host_cfg_reload,
  // comparator levels, asynchronous
  input  wire bss_sense_t sense_in,
  // rail enables
  output bss_enables_t rail_en,
  // status
  output bss_status_t  status,
  // current limit and fault output, open drain
  output logic         current_limit_fault_output_o,
  output logic         current_limit_fault_output_oe_n,
  // host status link, open drain
  output logic         host_status_link_o,
  output logic         host_status_link_oe_n
);
  bss_sense_t   s;
  bss_status_t  status_q;
  bss_status_t  status_d;
  logic         buck_uvlo_q;
  logic         buck_uvlo_d;
  logic         pend0_q;
  logic         pend1_q;
  logic         tx_ready;
  logic         tx_valid;
  logic [7:0]   tx_data;
  logic         send0;
  logic         send1;
  logic         cfg_boot_q;
  logic [`BSS_MODE_W-1:0] mode_raw;
  logic [`BSS_MODE_W-1:0] mode_s;

  // status byte: register id in the low bits, status bits above it
  function automatic logic [7:0] msg_byte(input logic [7:0] id, input logic [2:0] bits);
    msg_byte = id | (8'(bits) << `BSS_MSG_FIELD_LSB);
  endfunction : msg_byte

  // mode pins come from outside the clock domain
  assign mode_raw = {chip_enable, sleep_req, transceiver_variant, host_cfg_reload};

  bss_sync #(.W(`BSS_MODE_W)) u_mode_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (mode_raw),
    .sync_out (mode_s)
  );

  wire ce_s     = mode_s[`BSS_MODE_CE];
  wire sleep_s  = mode_s[`BSS_MODE_SLEEP];
  wire xcvr_s   = mode_s[`BSS_MODE_XCVR];
  wire reload_s = mode_s[`BSS_MODE_RELOAD];

  bss_sync #(.W($bits(bss_sense_t))) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (sense_in),
    .sync_out (s)
  );

  // operating state and fault terms
  wire system_off   = s.vdd_above_sys_ovlo;
  wire active       = ce_s && !system_off;
  wire standby      = !ce_s && !sleep_s && !system_off;
  wire drv_ov       = xcvr_s && s.vdd_above_drv_ovlo;
  wire supply_fault = s.vdd_below_uvlo || drv_ov;
  wire buck_stop    = s.vdd_above_ovlo_stop || s.vdd_below_bk_stop
                      || s.vdd_below_severe_uv || s.fb_held_external;
  wire buck_lockout = s.buck_out_below_80 || s.vdd_below_bk_stop;
  wire any_fault    = buck_uvlo_q || supply_fault || system_off;

  // lockout latches on a fault and holds while chip enable is high, released by chip enable low
  assign buck_uvlo_d = buck_lockout || (buck_uvlo_q && ce_s);

  // status bits
  always_comb begin
    status_d = status_q;
    status_d.first_status_register[`BSS_ST0_BIOCP] = s.buck_ipeak_over;
    if (s.buck_out_below_90)
      status_d.first_status_register[`BSS_ST0_BUCK_OUTPUT_LOW_WARNING] = 1'b1;
    else if (!s.buck_out_below_94)
      status_d.first_status_register[`BSS_ST0_BUCK_OUTPUT_LOW_WARNING] = 1'b0;
    status_d.first_status_register[`BSS_ST0_BUCK_LOCKOUT_FAULT] = buck_uvlo_d;
    status_d.second_status_register[`BSS_ST1_UV] = s.vdd_below_uvlo;
    status_d.second_status_register[`BSS_ST1_OV] = drv_ov || system_off;
    if (s.vdd_below_brownout || cfg_boot_q)
      status_d.second_status_register[`BSS_ST1_CFGLOST] = 1'b1;
    else if (reload_s)
      status_d.second_status_register[`BSS_ST1_CFGLOST] = 1'b0;
  end

  // one pending message per register, set when its bits change
  assign send0 = status_d.first_status_register != status_q.first_status_register;
  assign send1 = status_d.second_status_register
                 != status_q.second_status_register;
  assign tx_valid = pend0_q || pend1_q;
  assign tx_data  = pend0_q
                    ? msg_byte(`BSS_MSG_STATUS0, status_q.first_status_register)
                    : msg_byte(`BSS_MSG_STATUS1, status_q.second_status_register);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_q    <= '0;
      buck_uvlo_q <= 1'b0;
      cfg_boot_q  <= 1'b1;
      pend0_q     <= 1'b0;
      pend1_q     <= 1'b0;
    end else begin
      status_q    <= status_d;
      buck_uvlo_q <= buck_uvlo_d;
      cfg_boot_q  <= 1'b0;
      pend0_q     <= send0 || (pend0_q && !tx_ready);
      pend1_q     <= send1 || (pend1_q && !(tx_ready && !pend0_q));
    end
  end

  bss_uart_tx u_tx (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .tx_valid  (tx_valid),
    .tx_data   (tx_data),
    .tx_ready  (tx_ready),
    .link_o    (host_status_link_o),
    .link_oe_n (host_status_link_oe_n)
  );

  // rail enables
  assign rail_en.buck_en   = !system_off && !buck_stop && !buck_uvlo_q
                             && (active || standby);
  assign rail_en.ldo12_en  = active && !supply_fault && !buck_uvlo_q;
  assign rail_en.ldo5_en   = !system_off && !sleep_s
                             && (ce_s || xcvr_s)
                             && (!buck_uvlo_q || !ce_s);
  assign rail_en.pump_en   = rail_en.ldo12_en && s.vdd_below_pump_start;
  assign rail_en.drivers_en = active && !any_fault;
  assign status            = status_q;

  assign current_limit_fault_output_o    = 1'b0;
  assign current_limit_fault_output_oe_n = !(ce_s && any_fault);

  fault_pin_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce_s && buck_uvlo_q |-> !current_limit_fault_output_oe_n)
    else $error("fault output not low on lockout");
  ocp_keeps_buck_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.buck_ipeak_over && !buck_stop && !buck_uvlo_q && active |-> rail_en.buck_en)
    else $error("buck stopped by overcurrent warning");
  hyst_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    status_q.first_status_register[`BSS_ST0_BUCK_OUTPUT_LOW_WARNING] && s.buck_out_below_94
    |=> status_q.first_status_register[`BSS_ST0_BUCK_OUTPUT_LOW_WARNING])
    else $error("low warning cleared above hysteresis");
  buck_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    buck_stop |-> !rail_en.buck_en)
    else $error("buck enabled under stop condition");
  ldo12_ce_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ce_s |-> !rail_en.ldo12_en)
    else $error("12V regulator on without chip enable");
  brownout_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.vdd_below_brownout |=> status_q.second_status_register[`BSS_ST1_CFGLOST])
    else $error("config lost not set on brownout");
  drivers_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    supply_fault |-> !rail_en.drivers_en)
    else $error("drivers on during supply fault");
  all_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    system_off |-> rail_en == '0)
    else $error("rail on in extreme overvoltage");
  msg_queued_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    send0 |=> pend0_q)
    else $error("status change not queued");
  pump_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !s.vdd_below_pump_start |-> !rail_en.pump_en)
    else $error("pump on above start threshold");

  // message hand-off: a byte accepted by an idle transmitter starts a frame
  sequence byte_accepted;
    tx_valid && tx_ready;
  endsequence
  sequence start_bit_driven;
    !host_status_link_oe_n;
  endsequence
  msg_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    byte_accepted |=> start_bit_driven)
    else $error("accepted status byte did not start a frame");

  // lockout: condition seen, then latched and flagged
  sequence lockout_seen;
    buck_lockout;
  endsequence
  lockout_latch_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    lockout_seen |=> buck_uvlo_q && status_q.first_status_register[`BSS_ST0_BUCK_LOCKOUT_FAULT])
    else $error("lockout condition not latched");
  ocp_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.buck_ipeak_over |=> status_q.first_status_register[`BSS_ST0_BIOCP])
    else $error("overcurrent warning not set");
  ocp_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !s.buck_ipeak_over |=> !status_q.first_status_register[`BSS_ST0_BIOCP])
    else $error("overcurrent warning not cleared");
  low_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.buck_out_below_90 |=> status_q.first_status_register[`BSS_ST0_BUCK_OUTPUT_LOW_WARNING])
    else $error("buck low warning not set");
  uv_report_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.vdd_below_uvlo |=> status_q.second_status_register[`BSS_ST1_UV])
    else $error("undervoltage not reported");
  ovlo_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.vdd_above_ovlo_stop |-> !rail_en.buck_en)
    else $error("buck on above overvoltage stop");
  severe_uv_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.vdd_below_severe_uv |-> !rail_en.buck_en)
    else $error("buck on in severe undervoltage");
  fb_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.fb_held_external |-> !rail_en.buck_en)
    else $error("buck on with feedback held");
  pump_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rail_en.ldo12_en && s.vdd_below_pump_start |-> rail_en.pump_en)
    else $error("pump off below start threshold");
  ldo5_sleep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ce_s && sleep_s |-> !rail_en.ldo5_en)
    else $error("5V regulator on in sleep");
  fault_any_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce_s && any_fault |-> !current_limit_fault_output_oe_n)
    else $error("fault output released during fault");
endmodule : bss_supervisor

// [tb/bss_host_rx.sv]
// host side receiver model for the single-wire status link
`timescale 1ns/10ps
`include "bss_params.svh"
module bss_host_rx (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // level seen on the pulled-up wire
  input  wire logic       link_level,
  // received character
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_frame_err
);
  localparam int BitCycles = `BSS_BIT_CYCLES;
  int         cnt_q;
  logic [3:0] bit_q;
  logic       busy_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q        <= 0;
      bit_q        <= 4'h0;
      busy_q       <= 1'b0;
      rx_byte      <= 8'h00;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!busy_q) begin
        if (!link_level) begin
          busy_q <= 1'b1;
          bit_q  <= 4'h0;
          cnt_q  <= BitCycles / 2;
        end
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end else begin
        cnt_q <= BitCycles - 1;
        bit_q <= bit_q + 4'h1;
        if (bit_q >= 4'h1 && bit_q <= 4'h8) begin
          rx_byte <= {link_level, rx_byte[7:1]};
        end
        if (bit_q == 4'h9) begin
          busy_q       <= 1'b0;
          rx_valid     <= 1'b1;
          rx_frame_err <= !link_level;
        end
      end
    end
  end
endmodule : bss_host_rx

// [tb/testbench.sv]
// self-checking bench for the bias supply supervisor
`timescale 1ns/10ps
module testbench
  import bss_pkg::*;
;
  logic sys_clk, rstn, ce, slp, var_t, reload, rx_valid, rx_err;
  logic [7:0] rx_byte;
  bss_sense_t s, t;
  bss_enables_t rail_en;
  bss_status_t st;
  logic flt_o, flt_oe_n, lnk_o, lnk_oe_n;
  int err_total, checks, cyc;
  logic [31:0] r;
  bss_supervisor u_dut (.sys_clk(sys_clk), .rstn(rstn), .chip_enable(ce), .sleep_req(slp),
    .transceiver_variant(var_t), .host_cfg_reload(reload), .sense_in(s), .rail_en(rail_en),
    .status(st), .current_limit_fault_output_o(flt_o),
    .current_limit_fault_output_oe_n(flt_oe_n), .host_status_link_o(lnk_o),
    .host_status_link_oe_n(lnk_oe_n));
  bss_host_rx u_host (.sys_clk(sys_clk), .rstn(rstn), .link_level(lnk_oe_n ? 1'b1 : lnk_o),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_err(rx_err));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic settle(input bss_sense_t v, input logic c);
    @(negedge sys_clk);
    s  = v;
    ce = c;
    repeat (4) @(negedge sys_clk);
  endtask : settle
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 130000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    {rstn, ce, slp, reload} = 4'h0;
    var_t = 1'b1;
    s = '0;
    r = 32'h5eb9b7e6;
    repeat (12) @(negedge sys_clk);
    chk("status_rst", 8'h00, {2'b00, st});
    chk("link_rst", 8'h01, {7'h00, lnk_oe_n});
    chk("pins_low", 8'h00, {6'h00, flt_o, lnk_o});
    rstn = 1'b1;
    settle('0, 1'b1);
    chk("cfg_lost", 8'h01, {7'h00, st.second_status_register[0]});
    t = '0;
    t.buck_out_below_90 = 1'b1;
    t.buck_out_below_94 = 1'b1;
    settle(t, 1'b1);
    chk("low_set", 8'h01, {7'h00, st.first_status_register[1]});
    t.buck_out_below_90 = 1'b0;
    settle(t, 1'b1);
    chk("low_hyst", 8'h01, {7'h00, st.first_status_register[1]});
    settle('0, 1'b1);
    chk("low_clr", 8'h00, {7'h00, st.first_status_register[1]});
    t.buck_out_below_80 = 1'b1;
    t.buck_out_below_90 = 1'b1;
    settle(t, 1'b1);
    chk("lock_out", 8'h01, {7'h00, st.first_status_register[2]});
    chk("flt_pin", 8'h00, {7'h00, flt_oe_n});
    settle('0, 1'b1);
    chk("flt_hold", 8'h00, {7'h00, flt_oe_n});
    settle('0, 1'b0);
    chk("flt_rel", 8'h01, {7'h00, flt_oe_n});
    t = '0;
    t.vdd_below_bk_stop = 1'b1;
    settle(t, 1'b1);
    chk("lock_in", 8'h01, {7'h00, st.first_status_register[2]});
    chk("buck_uv", 8'h00, {7'h00, rail_en.buck_en});
    settle('0, 1'b0);
    $display("test fixed cases done");
    repeat (100) begin
      r = lfsr(lfsr(r));
      var_t = r[13];
      slp = r[14];
      t = bss_sense_t'(r[12:0] & r[28:16]);
      t.buck_out_below_80 = 1'b0;
      t.vdd_below_bk_stop = 1'b0;
      t.buck_ipeak_over = r[31];
      t.vdd_below_pump_start = r[30];
      t.buck_out_below_94 = t.buck_out_below_94 | t.buck_out_below_90;
      settle(t, r[29] | r[15]);
      t.buck_ipeak_over = 1'b0;
      t.vdd_below_pump_start = 1'b0;
      chk("ocp_bit", {7'h00, s.buck_ipeak_over}, {7'h00, st.first_status_register[0]});
      chk("uv_bit", {7'h00, s.vdd_below_uvlo}, {7'h00, st.second_status_register[1]});
      chk("ov_bit", {7'h00, (s.vdd_above_drv_ovlo & var_t) | s.vdd_above_sys_ovlo},
        {7'h00, st.second_status_register[2]});
      if (!ce) chk("ldo12", 8'h00, {7'h00, rail_en.ldo12_en});
      if (!ce && slp) chk("ldo5_slp", 8'h00, {7'h00, rail_en.ldo5_en});
      if (!ce && !slp && t == '0) chk("ldo5_sby", {7'h00, var_t}, {7'h00, rail_en.ldo5_en});
      if (s.vdd_below_uvlo || (s.vdd_above_drv_ovlo && var_t))
        chk("drv", 8'h00, {7'h00, rail_en.drivers_en});
      if (s.vdd_above_sys_ovlo) chk("all_off", 8'h00, {3'h0, rail_en});
      if (s.vdd_above_ovlo_stop || s.vdd_below_severe_uv || s.fb_held_external)
        chk("buck_off", 8'h00, {7'h00, rail_en.buck_en});
      if (t == '0 && !(!ce && slp)) chk("buck_on", 8'h01, {7'h00, rail_en.buck_en});
      if (!s.vdd_below_pump_start) chk("pump_off", 8'h00, {7'h00, rail_en.pump_en});
      else if (ce && t == '0) chk("pump_on", 8'h01, {7'h00, rail_en.pump_en});
    end
    $display("test random cases done");
    settle('0, 1'b1);
    while (!rx_valid) @(negedge sys_clk);
    chk("msg", 8'h21, rx_byte);
    chk("stop_bit", 8'h00, {7'h00, rx_err});
    reload = 1'b1;
    settle('0, 1'b1);
    reload = 1'b0;
    chk("cfg_clr", 8'h00, {7'h00, st.second_status_register[0]});
    $display("test link done");
    report_and_stop();
  end
endmodule : testbench
